// file: shared/intr_capture_pkg.sv
package intr_capture_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int XLEN  = 32;
  localparam int VEC_W = 6;
  localparam int ADR_W = 8;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [ADR_W-1:0] OFS_STATUS    = 8'h00;
  localparam logic [ADR_W-1:0] OFS_SAVED_ST  = 8'h04;
  localparam logic [ADR_W-1:0] OFS_SAVED_BP  = 8'h08;
  localparam logic [ADR_W-1:0] OFS_CAUSE     = 8'h0C;
  localparam logic [ADR_W-1:0] OFS_FAULT_AD  = 8'h10;
  localparam logic [ADR_W-1:0] OFS_REGION    = 8'h14;
  localparam logic [ADR_W-1:0] OFS_LAST_RET  = 8'h18;
  localparam logic [ADR_W-1:0] OFS_IMMED     = 8'h1C;
  localparam logic [ADR_W-1:0] OFS_HASH      = 8'h20;
  localparam logic [ADR_W-1:0] OFS_FRAME     = 8'h24;
  localparam logic [ADR_W-1:0] OFS_VBASE     = 8'h28;
  localparam logic [ADR_W-1:0] OFS_DEFAULTS  = 8'h2C;
  localparam logic [ADR_W-1:0] OFS_SERIALIZE = 8'h30;
  localparam logic [ADR_W-1:0] OFS_SERVICE   = 8'h34;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int SW_BE       = 1;
  localparam int SW_BN       = 12;
  localparam int SW_IC       = 13;
  localparam int SW_I        = 14;
  localparam int SW_PP       = 21;
  localparam int SW_RI       = 30;
  localparam int DEF_BE      = 0;
  localparam int DEF_PP      = 1;
  localparam int FRAME_VALID = 31;
  localparam int CAUSE_SLOT  = 24;
  localparam int SER_DATA    = 0;
  localparam int SER_INSTR   = 1;
  localparam int SVC_STATUS  = 0;
  localparam int SVC_VBASE   = 1;
  localparam int SVC_DEF     = 2;
  localparam int SVC_NESTED  = 3;

  // ------------------------------------------------------------
  // reset values and vector table sizing
  // ------------------------------------------------------------
  localparam logic [XLEN-1:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [XLEN-1:0] VBASE_RESET  = 32'h0000_0000;
  localparam logic [XLEN-1:0] DEF_RESET    = 32'h0000_0000;
  localparam logic [XLEN-1:0] ZERO_WORD    = 32'h0000_0000;
  localparam int LIGHT_COUNT = 20;
  localparam int LIGHT_BYTES = 1024;
  localparam int HEAVY_BYTES = 256;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [3:0]       sel;
    logic [XLEN-1:0]  dat;
  } wb_req_t;

  typedef struct packed {
    logic [VEC_W-1:0] vec_num;
    logic [XLEN-1:0]  bundle;
    logic [1:0]       slot;
    logic [XLEN-1:0]  cause;
    logic             has_addr;
    logic [XLEN-1:0]  fault_addr;
    logic [XLEN-1:0]  region_attr;
    logic             has_imm;
    logic [XLEN-1:0]  immediate;
    logic             has_hash;
    logic [XLEN-1:0]  hash_addr;
  } intr_req_t;

endpackage

// file: design/vector_locator.sv
module vector_locator
  import intr_capture_pkg::*;
#(
  parameter int LIGHT_N  = LIGHT_COUNT,
  parameter int LIGHT_SZ = LIGHT_BYTES,
  parameter int HEAVY_SZ = HEAVY_BYTES
) (
  input  wire logic [VEC_W-1:0] vec_num,
  input  wire logic [XLEN-1:0]  base,
  output logic      [XLEN-1:0]  entry
);

  // ------------------------------------------------------------
  // entry offset: lightweight slots first, heavyweight after
  // ------------------------------------------------------------
  logic [XLEN-1:0] offset;

  always_comb begin
    if (32'(vec_num) < 32'(LIGHT_N)) begin
      offset = 32'(32'(vec_num) * LIGHT_SZ);
    end else begin
      offset = 32'(LIGHT_N * LIGHT_SZ + (32'(vec_num) - LIGHT_N) * HEAVY_SZ);
    end
  end

  assign entry = base + offset;

endmodule

// file: design/interruption_state_capture.sv
module interruption_state_capture
  import intr_capture_pkg::*;
(
  input  wire logic            core_clk,
  input  wire logic            reset_n,
  input  wire wb_req_t         wb_req,
  output logic                 wb_ack_o,
  output logic      [XLEN-1:0] wb_dat_o,
  input  wire logic            intr_valid,
  input  wire intr_req_t       intr_req,
  input  wire logic            retire_valid,
  input  wire logic [XLEN-1:0] retire_bundle,
  input  wire logic            rfi_valid,
  input  wire logic            srlz_d,
  input  wire logic            srlz_i,
  output logic      [XLEN-1:0] status_word,
  output logic      [XLEN-1:0] vector_base,
  output logic                 handler_go,
  output logic      [XLEN-1:0] handler_addr,
  output logic                 nested_go,
  output logic                 resume_go,
  output logic      [XLEN-1:0] resume_addr,
  output logic      [1:0]      resume_slot
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic            ack_r;
  logic [XLEN-1:0] rd_r;
  logic [XLEN-1:0] rd_nxt;
  logic [XLEN-1:0] status_act_r;
  logic [XLEN-1:0] status_pend_r;
  logic [XLEN-1:0] vbase_act_r;
  logic [XLEN-1:0] vbase_pend_r;
  logic [XLEN-1:0] def_act_r;
  logic [XLEN-1:0] def_pend_r;
  logic [XLEN-1:0] saved_status_copy_r;
  logic [XLEN-1:0] saved_bundle_pointer_r;
  logic [XLEN-1:0] cause_detail_r;
  logic [XLEN-1:0] fault_address_r;
  logic [XLEN-1:0] fault_region_attr_r;
  logic [XLEN-1:0] last_retired_bundle_r;
  logic [XLEN-1:0] fault_immediate_r;
  logic [XLEN-1:0] hash_address_r;
  logic [XLEN-1:0] saved_frame_r;
  logic            nested_last_r;
  logic            handler_go_r;
  logic [XLEN-1:0] handler_addr_r;
  logic            nested_go_r;
  logic            resume_go_r;
  logic [XLEN-1:0] resume_addr_r;
  logic [1:0]      resume_slot_r;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic            wb_hit;
  logic            wr_fire;
  logic [XLEN-1:0] wr_word;
  logic            ser_wr;
  logic            ser_d;
  logic            ser_i;

  function automatic logic [XLEN-1:0] merge(input logic [XLEN-1:0] old_v,
                                            input logic [XLEN-1:0] new_v,
                                            input logic [3:0]      sel);
    logic [XLEN-1:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  assign wb_hit  = wb_req.cyc & wb_req.stb;
  assign wr_fire = wb_hit & wb_req.we & ack_r;
  assign wr_word = merge(ZERO_WORD, wb_req.dat, wb_req.sel);

  function automatic logic wr_to(input logic [ADR_W-1:0] ofs);
    return wr_fire && (wb_req.adr == ofs);
  endfunction

  // serialize from the pipeline or from the command register
  assign ser_wr = wr_fire & (wb_req.adr == OFS_SERIALIZE);
  assign ser_d  = srlz_d | (ser_wr & wr_word[SER_DATA]);
  assign ser_i  = srlz_i | (ser_wr & wr_word[SER_INSTR]);

  // ------------------------------------------------------------
  // delivery and return decisions
  // ------------------------------------------------------------
  logic            take_intr;
  logic            take_rfi;
  logic            ic_inflight;
  logic            collect;
  logic [XLEN-1:0] status_at_intr;
  logic [XLEN-1:0] status_handler;
  logic [XLEN-1:0] entry_addr;

  assign take_intr   = intr_valid;
  assign take_rfi    = rfi_valid & ~intr_valid;
  assign ic_inflight = status_pend_r[SW_IC] ^ status_act_r[SW_IC];
  assign collect     = take_intr & status_act_r[SW_IC] & ~ic_inflight;

  always_comb begin
    // pending status commits, except the collection bit
    status_at_intr        = status_pend_r;
    status_at_intr[SW_IC] = status_act_r[SW_IC];
    status_handler        = status_at_intr;
    status_handler[SW_I]  = 1'b0;
    status_handler[SW_IC] = 1'b0;
    status_handler[SW_BN] = 1'b0;
    status_handler[SW_BE] = def_act_r[DEF_BE];
    status_handler[SW_PP] = def_act_r[DEF_PP];
    status_handler[SW_RI +: 2] = 2'h0;
  end

  // base taken from the active copy only: not serialized by delivery
  vector_locator u_vector_locator (
    .vec_num (intr_req.vec_num),
    .base    (vbase_act_r),
    .entry   (entry_addr)
  );

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_hit & ~ack_r;
    end
  end

  always_comb begin
    rd_nxt = ZERO_WORD;
    case (wb_req.adr)
      OFS_STATUS:    rd_nxt = status_pend_r;
      OFS_SAVED_ST:  rd_nxt = saved_status_copy_r;
      OFS_SAVED_BP:  rd_nxt = saved_bundle_pointer_r;
      OFS_CAUSE:     rd_nxt = cause_detail_r;
      OFS_FAULT_AD:  rd_nxt = fault_address_r;
      OFS_REGION:    rd_nxt = fault_region_attr_r;
      OFS_LAST_RET:  rd_nxt = last_retired_bundle_r;
      OFS_IMMED:     rd_nxt = fault_immediate_r;
      OFS_HASH:      rd_nxt = hash_address_r;
      OFS_FRAME:     rd_nxt = saved_frame_r;
      OFS_VBASE:     rd_nxt = vbase_pend_r;
      OFS_DEFAULTS:  rd_nxt = def_pend_r;
      OFS_SERVICE: begin
        rd_nxt[SVC_STATUS] = |(status_pend_r ^ status_act_r);
        rd_nxt[SVC_VBASE]  = |(vbase_pend_r ^ vbase_act_r);
        rd_nxt[SVC_DEF]    = |(def_pend_r ^ def_act_r);
        rd_nxt[SVC_NESTED] = nested_last_r;
      end
      default:       rd_nxt = ZERO_WORD;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_r <= ZERO_WORD;
    end else if (wb_hit & ~ack_r) begin
      rd_r <= rd_nxt;
    end
  end

  // ------------------------------------------------------------
  // status word: staged and active copies
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_pend_r <= STATUS_RESET;
    end else if (take_intr) begin
      status_pend_r <= status_handler;
    end else if (take_rfi) begin
      status_pend_r <= saved_status_copy_r;
    end else if (wr_to(OFS_STATUS)) begin
      status_pend_r <= merge(status_pend_r, wb_req.dat, wb_req.sel);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_act_r <= STATUS_RESET;
    end else if (take_intr) begin
      status_act_r <= status_handler;
    end else if (take_rfi) begin
      status_act_r <= saved_status_copy_r;
    end else if (ser_d | ser_i) begin
      status_act_r <= status_pend_r;
    end
  end

  // ------------------------------------------------------------
  // vector base and handler defaults
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      vbase_pend_r <= VBASE_RESET;
      def_pend_r   <= DEF_RESET;
    end else begin
      if (wr_to(OFS_VBASE)) begin
        vbase_pend_r <= merge(vbase_pend_r, wb_req.dat, wb_req.sel);
      end
      if (wr_to(OFS_DEFAULTS)) begin
        def_pend_r <= merge(def_pend_r, wb_req.dat, wb_req.sel);
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      vbase_act_r <= VBASE_RESET;
      def_act_r   <= DEF_RESET;
    end else if (!take_intr) begin
      if (ser_i | take_rfi) begin
        vbase_act_r <= vbase_pend_r;
      end
      if (ser_d | ser_i | take_rfi) begin
        def_act_r <= def_pend_r;
      end
    end
  end

  // ------------------------------------------------------------
  // interruption registers written on every collected interruption
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      saved_status_copy_r    <= ZERO_WORD;
      saved_bundle_pointer_r <= ZERO_WORD;
      cause_detail_r         <= ZERO_WORD;
      saved_frame_r          <= ZERO_WORD;
    end else if (collect) begin
      saved_status_copy_r               <= status_at_intr;
      saved_status_copy_r[SW_RI +: 2]   <= intr_req.slot;
      saved_bundle_pointer_r            <= intr_req.bundle;
      cause_detail_r                    <= intr_req.cause;
      cause_detail_r[CAUSE_SLOT +: 2]   <= intr_req.slot;
      saved_frame_r[FRAME_VALID]        <= 1'b0;
    end else if (!take_intr) begin
      if (wr_to(OFS_SAVED_ST)) begin
        saved_status_copy_r <= merge(saved_status_copy_r, wb_req.dat, wb_req.sel);
      end
      if (wr_to(OFS_SAVED_BP)) begin
        saved_bundle_pointer_r <= merge(saved_bundle_pointer_r, wb_req.dat, wb_req.sel);
      end
      if (wr_to(OFS_CAUSE)) begin
        cause_detail_r <= merge(cause_detail_r, wb_req.dat, wb_req.sel);
      end
      if (wr_to(OFS_FRAME)) begin
        saved_frame_r <= merge(saved_frame_r, wb_req.dat, wb_req.sel);
      end
    end
  end

  // ------------------------------------------------------------
  // fault-specific interruption registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_address_r     <= ZERO_WORD;
      fault_region_attr_r <= ZERO_WORD;
    end else if (collect & intr_req.has_addr) begin
      fault_address_r     <= intr_req.fault_addr;
      fault_region_attr_r <= intr_req.region_attr;
    end else if (!take_intr) begin
      if (wr_to(OFS_FAULT_AD)) begin
        fault_address_r <= merge(fault_address_r, wb_req.dat, wb_req.sel);
      end
      if (wr_to(OFS_REGION)) begin
        fault_region_attr_r <= merge(fault_region_attr_r, wb_req.dat, wb_req.sel);
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_immediate_r <= ZERO_WORD;
    end else if (collect & intr_req.has_imm) begin
      fault_immediate_r <= intr_req.immediate;
    end else if (!take_intr & wr_to(OFS_IMMED)) begin
      fault_immediate_r <= merge(fault_immediate_r, wb_req.dat, wb_req.sel);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hash_address_r <= ZERO_WORD;
    end else if (collect & intr_req.has_hash) begin
      hash_address_r <= intr_req.hash_addr;
    end else if (!take_intr & wr_to(OFS_HASH)) begin
      hash_address_r <= merge(hash_address_r, wb_req.dat, wb_req.sel);
    end
  end

  // ------------------------------------------------------------
  // last retired bundle
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      last_retired_bundle_r <= ZERO_WORD;
    end else if (retire_valid & status_act_r[SW_IC]) begin
      last_retired_bundle_r <= retire_bundle;
    end else if (wr_to(OFS_LAST_RET)) begin
      last_retired_bundle_r <= merge(last_retired_bundle_r, wb_req.dat, wb_req.sel);
    end
  end

  // ------------------------------------------------------------
  // handler entry and return redirect
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      handler_go_r   <= 1'b0;
      handler_addr_r <= ZERO_WORD;
      nested_go_r    <= 1'b0;
      nested_last_r  <= 1'b0;
    end else begin
      handler_go_r <= take_intr;
      nested_go_r  <= take_intr & ~collect;
      if (take_intr) begin
        handler_addr_r <= entry_addr;
        nested_last_r  <= ~collect;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      resume_go_r   <= 1'b0;
      resume_addr_r <= ZERO_WORD;
      resume_slot_r <= 2'h0;
    end else begin
      resume_go_r <= take_rfi;
      if (take_rfi) begin
        resume_addr_r <= saved_bundle_pointer_r;
        resume_slot_r <= saved_status_copy_r[SW_RI +: 2];
      end
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign wb_ack_o     = ack_r;
  assign wb_dat_o     = rd_r;
  assign status_word  = status_act_r;
  assign vector_base  = vbase_act_r;
  assign handler_go   = handler_go_r;
  assign handler_addr = handler_addr_r;
  assign nested_go    = nested_go_r;
  assign resume_go    = resume_go_r;
  assign resume_addr  = resume_addr_r;
  assign resume_slot  = resume_slot_r;

endmodule

// file: verif/pipe_model.sv
module pipe_model
  import intr_capture_pkg::*;
(
  input  wire logic            core_clk,
  output logic                 intr_valid,
  output intr_req_t            intr_req,
  output logic                 retire_valid,
  output logic      [XLEN-1:0] retire_bundle,
  output logic                 rfi_valid,
  output logic                 srlz_d,
  output logic                 srlz_i
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {intr_valid, retire_valid, rfi_valid, srlz_d, srlz_i} = 5'h00;
    intr_req      = '0;
    retire_bundle = '0;
  end
  // one-cycle delivery; fields scrambled once valid drops
  task automatic deliver(input intr_req_t r);
    @(posedge core_clk);
    intr_req   <= r;
    intr_valid <= 1'b1;
    @(posedge core_clk);
    intr_req   <= intr_req_t'(~r);
    intr_valid <= 1'b0;
  endtask
  // m: retire, return, instr serialize, data serialize
  task automatic step(input logic [3:0] m, input logic [XLEN-1:0] b);
    @(posedge core_clk);
    {retire_valid, rfi_valid, srlz_i, srlz_d} <= m;
    retire_bundle <= b;
    @(posedge core_clk);
    {retire_valid, rfi_valid, srlz_i, srlz_d} <= 4'h0;
    retire_bundle <= ~b;
  endtask
endmodule

// file: verif/interruption_state_capture_assertions.sv
module capture_checker
  import intr_capture_pkg::*;
(
  input wire logic            core_clk,
  input wire logic            reset_n,
  input wire wb_req_t         wb_req,
  input wire logic            wb_ack_o,
  input wire logic            intr_valid,
  input wire intr_req_t       intr_req,
  input wire logic            rfi_valid,
  input wire logic            srlz_d,
  input wire logic            srlz_i,
  input wire logic [XLEN-1:0] status_word,
  input wire logic [XLEN-1:0] vector_base,
  input wire logic            handler_go,
  input wire logic [XLEN-1:0] handler_addr,
  input wire logic            nested_go,
  input wire logic            resume_go,
  input wire logic [1:0]      resume_slot
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic            ser_wr;
  logic            chg_ok;
  logic [XLEN-1:0] entry_q;
  assign ser_wr = wb_ack_o & wb_req.we & (wb_req.adr == OFS_SERIALIZE);
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      entry_q <= '0;
      chg_ok  <= 1'b0;
    end else begin
      entry_q <= (intr_req.vec_num < LIGHT_COUNT) ? XLEN'(intr_req.vec_num * LIGHT_BYTES)
        : XLEN'(LIGHT_COUNT * LIGHT_BYTES + (intr_req.vec_num - LIGHT_COUNT) * HEAVY_BYTES);
      chg_ok  <= srlz_d | srlz_i | intr_valid | rfi_valid | ser_wr;
    end
  end
  ack_timing_a: assert property (wb_req.cyc && wb_req.stb && !wb_ack_o
    |=> wb_ack_o ##1 !wb_ack_o) else $error("bus ack timing wrong");
  handler_timing_a: assert property (intr_valid |=> handler_go)
    else $error("no handler entry after delivery");
  handler_cause_a: assert property (handler_go |-> $past(intr_valid))
    else $error("handler entry without delivery");
  nested_sub_a: assert property (nested_go |-> handler_go)
    else $error("nested flag without handler entry");
  entry_addr_a: assert property (handler_go |-> handler_addr == vector_base + entry_q)
    else $error("handler entry address wrong");
  delivery_clears_a: assert property (handler_go |-> !status_word[SW_I] && !status_word[SW_IC]
    && !status_word[SW_BN] && status_word[SW_RI+1:SW_RI] == 2'h0)
    else $error("status bits not cleared on delivery");
  resume_timing_a: assert property (rfi_valid && !intr_valid |=> resume_go
    && resume_slot == status_word[SW_RI+1:SW_RI])
    else $error("return redirect wrong");
  resume_cause_a: assert property (resume_go |-> $past(rfi_valid))
    else $error("redirect without return");
  status_commit_a: assert property (!$stable(status_word) |-> chg_ok)
    else $error("status changed without serialization");
  cover property (handler_go && nested_go);
  cover property (handler_go && !nested_go);
  cover property (resume_go);
endmodule

// file: verif/interruption_state_capture_tb.sv
module interruption_state_capture_tb
  import intr_capture_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic            core_clk;
  logic            reset_n;
  wb_req_t         wb_req;
  intr_req_t       intr_req;
  logic            wb_ack_o, intr_valid, retire_valid, rfi_valid, srlz_d, srlz_i;
  logic            handler_go, nested_go, resume_go;
  logic [1:0]      resume_slot;
  logic [XLEN-1:0] wb_dat_o, status_word, vector_base, handler_addr, resume_addr;
  logic [XLEN-1:0] retire_bundle, q;
  int              err_total, compares;
  localparam logic [ADR_W-1:0] CAP_OFS [8] = '{OFS_SAVED_ST, OFS_SAVED_BP, OFS_CAUSE,
    OFS_FAULT_AD, OFS_REGION, OFS_IMMED, OFS_HASH, OFS_FRAME};
  localparam logic [XLEN-1:0] CAP_EXP [8] = '{32'h8000_3000, 32'h0000_A0D0, 32'h0200_0055,
    32'h1234_5678, 32'h0000_0B20, 32'h0000_0777, 32'h00C0_FFE0, 32'h7FFF_FFFF};
  interruption_state_capture i_interruption_state_capture (.core_clk, .reset_n, .wb_req,
    .wb_ack_o, .wb_dat_o, .intr_valid, .intr_req, .retire_valid, .retire_bundle, .rfi_valid,
    .srlz_d, .srlz_i, .status_word, .vector_base, .handler_go, .handler_addr, .nested_go,
    .resume_go, .resume_addr, .resume_slot);
  pipe_model i_pipe_model (.core_clk, .intr_valid, .intr_req, .retire_valid,
    .retire_bundle, .rfi_valid, .srlz_d, .srlz_i);
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cmp(input string n, input logic [XLEN-1:0] e, input logic [XLEN-1:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [XLEN-1:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    wb_req <= '{1'b1, 1'b1, w, a, 4'hF, d};
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_req <= '0;
    if (wb_ack_o !== 1'b1) begin
      err_total++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [ADR_W-1:0] a, input logic [XLEN-1:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd(input logic [ADR_W-1:0] a, input logic [XLEN-1:0] e, input string n);
    wb(1'b0, a, 32'h0);
    cmp(n, e, q);
  endtask
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    intr_req_t r;
    r = '0;
    err_total = 0;
    compares = 0;
    reset_n = 1'b0;
    wb_req = '0;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    cmp("status", 32'h0, status_word);
    rd(8'h3C, 32'h0, "unmapped");
    wr(OFS_STATUS, 32'h0000_3000);
    cmp("status", 32'h0, status_word);
    rd(OFS_SERVICE, 32'h1, "service");
    i_pipe_model.step(4'h1, 32'h0);
    #1 cmp("status", 32'h0000_3000, status_word);
    wr(OFS_FRAME, 32'hFFFF_FFFF);
    wr(OFS_DEFAULTS, 32'h0000_0003);
    wr(OFS_SERIALIZE, 32'h0000_0001);
    i_pipe_model.step(4'h8, 32'h0000_A0C0);
    rd(OFS_LAST_RET, 32'h0000_A0C0, "last_ret");
    i_pipe_model.deliver('{6'h02, 32'h0000_A0D0, 2'h2, 32'h0000_0055, 1'b1, 32'h1234_5678,
      32'h0000_0B20, 1'b1, 32'h0000_0777, 1'b1, 32'h00C0_FFE0});
    #1 cmp("go", 32'h1, {31'h0, handler_go});
    cmp("nested", 32'h0, {31'h0, nested_go});
    cmp("entry", 32'h0000_0800, handler_addr);
    cmp("status", 32'h0020_0002, status_word);
    foreach (CAP_OFS[i]) rd(CAP_OFS[i], CAP_EXP[i], "capture");
    i_pipe_model.step(4'h8, 32'h000B_EEF0);
    rd(OFS_LAST_RET, 32'h0000_A0C0, "last_ret");
    r.vec_num = 6'h19;
    r.bundle = 32'h0000_0010;
    i_pipe_model.deliver(r);
    #1 cmp("nested", 32'h1, {31'h0, nested_go});
    cmp("entry", 32'h0000_5500, handler_addr);
    rd(OFS_SAVED_BP, 32'h0000_A0D0, "saved_bp");
    wr(OFS_SAVED_ST, 32'h4000_2000);
    wr(OFS_VBASE, 32'h0001_0000);
    i_pipe_model.step(4'h4, 32'h0);
    #1 cmp("status", 32'h4000_2000, status_word);
    cmp("resume_go", 32'h1, {31'h0, resume_go});
    cmp("resume", 32'h0000_A0D0, resume_addr);
    cmp("slot", 32'h1, {30'h0, resume_slot});
    cmp("vbase", 32'h0001_0000, vector_base);
    wr(OFS_VBASE, 32'h0002_0000);
    wr(OFS_STATUS, 32'h0);
    r.vec_num = 6'h00;
    i_pipe_model.deliver(r);
    #1 cmp("nested", 32'h1, {31'h0, nested_go});
    cmp("entry", 32'h0001_0000, handler_addr);
    cmp("vbase", 32'h0001_0000, vector_base);
    rd(OFS_SERVICE, 32'h0000_000A, "service");
    i_pipe_model.step(4'h2, 32'h0);
    #1 cmp("vbase", 32'h0002_0000, vector_base);
    wrap_up();
  end
endmodule
bind interruption_state_capture capture_checker i_capture_checker (.core_clk, .reset_n,
  .wb_req, .wb_ack_o, .intr_valid, .intr_req, .rfi_valid, .srlz_d, .srlz_i, .status_word,
  .vector_base, .handler_go, .handler_addr, .nested_go, .resume_go, .resume_slot);
